// ### core/sarc_cfg_if.sv
// Interface carrying the serial configuration port between top and config shifter.
// Assumes all signals are already synchronised to clk.
`timescale 1ns/1ps
interface sarc_cfg_if;
  logic                          sel_n;
  logic                          sclk;
  logic                          sdata;
  logic                          invert;
  logic                          enable;
  logic [sarc_pkg::CFG_W-1:0]    cfg;
  modport top (output sel_n, output sclk, output sdata, output invert, output enable,
               input cfg);
  modport shifter (input sel_n, input sclk, input sdata, input invert, input enable,
                   output cfg);
endinterface : sarc_cfg_if

// ### core/sarc_cfg_shift.sv
// Serial configuration shifter: shifts bits in on the chosen config clock edge.
// Assumes synchronised inputs; rst clears the whole configuration word.
`timescale 1ns/1ps
module sarc_cfg_shift (
  input  wire logic  clk,
  input  wire logic  rst,
  sarc_cfg_if.shifter port_i
);
  logic                       sclk_q;
  logic [sarc_pkg::CFG_W-1:0] cfg_q;
  logic                       edge_hit;

  ////////////////////////////////////////////////////////////////////////////
  // Active edge is rising, or falling when invert is high
  assign edge_hit = port_i.invert ? (sclk_q & ~port_i.sclk)
                                  : (~sclk_q & port_i.sclk);

  // Edge history runs through reset, so a clock idling high gives no false edge on release
  always_ff @(posedge clk) begin
    sclk_q <= port_i.sclk;
  end

  // Shift only in software mode and while the port select is low
  always_ff @(posedge clk) begin
    if (rst) begin
      cfg_q <= sarc_pkg::CFG_RST;
    end else if (port_i.enable && !port_i.sel_n && edge_hit) begin
      cfg_q <= {cfg_q[sarc_pkg::CFG_W-2:0], port_i.sdata};
    end
  end
  assign port_i.cfg = cfg_q;

  ////////////////////////////////////////////////////////////////////////////
  property p_cfg_hold;
    @(posedge clk) disable iff (rst)
      port_i.sel_n |=> $stable(cfg_q);
  endproperty
  a_cfg_hold: assert property (p_cfg_hold) else $error("config moved while deselected");
  property p_cfg_shift;
    @(posedge clk) disable iff (rst)
      (port_i.enable && !port_i.sel_n && edge_hit) |=> cfg_q[0] == $past(port_i.sdata);
  endproperty
  a_cfg_shift: assert property (p_cfg_shift) else $error("config bit not taken");
  c_cfg_shift: cover property (@(posedge clk) disable iff (rst)
    port_i.enable && !port_i.sel_n && edge_hit);
endmodule : sarc_cfg_shift

// ### core/sarc_ctrl.sv
// Pin control of a 16-bit SAR converter: busy, range decode, bus enable, reset, power-down.
// Assumes all pins are asynchronous to clk; the analog core result arrives on core_result.
`timescale 1ns/1ps
module sarc_ctrl (
  input  wire logic                        clk,
  input  wire logic                        rst,
  input  wire logic                        reset_pin,
  input  wire logic                        convert_start_n,
  input  wire logic                        power_down_in,
  input  wire logic                        range_polarity_select,
  input  wire logic                        range_span_select,
  input  wire logic                        chip_select_n,
  input  wire logic                        read_n,
  input  wire logic                        output_coding_select,
  input  wire logic                        serial_parallel_select,
  input  wire logic                        clock_source_select,
  input  wire logic                        read_during_convert,
  input  wire logic                        hardware_software_config_select,
  input  wire logic [1:0]                  conv_mode_pins,
  input  wire logic                        ext_serial_clock,
  input  wire logic                        config_port_select,
  input  wire logic                        config_port_clock,
  input  wire logic                        config_port_data_in,
  input  wire logic                        serial_clock_invert,
  input  wire logic [sarc_pkg::DATA_W-1:0] core_result,
  output logic                             busy,
  output logic                             data_ready,
  output sarc_pkg::sarc_range_t            input_range,
  output logic [sarc_pkg::DATA_W-1:0]      result_out,
  output logic                             result_oe,
  output logic                             serial_clock_gated,
  output logic [sarc_pkg::CFG_W-1:0]       config_word
);
  // Two-flop synchronisers for every pin, first stage read only by second
  localparam int NSYNC = 19;
  logic [NSYNC-1:0] raw, s1_q, s2_q;
  assign raw = {reset_pin, convert_start_n, power_down_in, range_polarity_select,
                range_span_select, chip_select_n, read_n, output_coding_select,
                serial_parallel_select, clock_source_select, read_during_convert,
                hardware_software_config_select, conv_mode_pins, ext_serial_clock,
                config_port_select, config_port_clock, config_port_data_in,
                serial_clock_invert};

  ////////////////////////////////////////////////////////////////////////////
  // Input synchronisers, one per pin; reset to each pin's idle level, not to zero
  genvar gi;
  generate
    for (gi = 0; gi < NSYNC; gi++) begin : g_sync
      always_ff @(posedge clk) begin
        if (rst) begin
          s1_q[gi] <= sarc_pkg::PIN_IDLE[gi];
          s2_q[gi] <= sarc_pkg::PIN_IDLE[gi];
        end else begin
          s1_q[gi] <= raw[gi];
          s2_q[gi] <= s1_q[gi];
        end
      end
    end
  endgenerate

  logic       rst_s, cnv_n_s, pd_s, pol_s, span_s, cs_n_s, rd_n_s, ob_s, ser_s;
  logic       clkint_s, rdc_s, hwsw_s, sclk_s, ccs_s, cclk_s, cdat_s, inv_s;
  logic [1:0] mode_s;
  assign {rst_s, cnv_n_s, pd_s, pol_s, span_s, cs_n_s, rd_n_s, ob_s, ser_s, clkint_s,
          rdc_s, hwsw_s, mode_s, sclk_s, ccs_s, cclk_s, cdat_s, inv_s} = s2_q;

  ////////////////////////////////////////////////////////////////////////////
  // Range decode from polarity and span
  function automatic sarc_pkg::sarc_range_t range_of(input logic pol, input logic span);
    range_of = sarc_pkg::sarc_range_t'({pol, span});
  endfunction : range_of

  always_ff @(posedge clk) begin
    if (rst) begin
      input_range <= sarc_pkg::SARC_RANGE_UNI5;
    end else begin
      input_range <= range_of(pol_s, span_s);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Conversion length per mode; master read-after-convert adds the same extra time to each mode
  function automatic logic [sarc_pkg::CNT_W-1:0] conv_len(input logic [1:0] m,
                                                          input logic rac);
    logic [sarc_pkg::CNT_W-1:0] base;
    base = 8'(sarc_pkg::CONV_NORMAL_CYC);
    case (m)
      2'h1:    base = 8'(sarc_pkg::CONV_WARP_CYC);
      2'h2:    base = 8'(sarc_pkg::CONV_IMPULSE_CYC);
      default: base = 8'(sarc_pkg::CONV_NORMAL_CYC);
    endcase
    conv_len = rac ? 8'(base + 8'(sarc_pkg::EXTRA_RAC_CYC)) : base;
  endfunction : conv_len

  logic master_rac;
  assign master_rac = ser_s & ~clkint_s & ~rdc_s;

  typedef enum logic [1:0] {SARC_IDLE, SARC_CONV, SARC_CAPT} sarc_state_t;
  sarc_state_t                 state_q;
  logic [sarc_pkg::CNT_W-1:0]  cnt_q;
  logic                        cnv_n_q, rst_s_q;
  logic                        start;

  // Start on the convert falling edge; power-down or reset refuse it
  assign start = cnv_n_q & ~cnv_n_s & ~pd_s & ~rst_s & (state_q == SARC_IDLE);

  always_ff @(posedge clk) begin
    if (rst) begin
      cnv_n_q <= 1'b1;
      rst_s_q <= 1'b0;
    end else begin
      cnv_n_q <= cnv_n_s;
      rst_s_q <= rst_s;
    end
  end

  // Conversion sequencer; power-down is not checked mid-run so it completes
  always_ff @(posedge clk) begin
    if (rst || rst_s) begin
      state_q <= SARC_IDLE;
      cnt_q   <= '0;
    end else begin
      case (state_q)
        SARC_IDLE: begin
          if (start) begin
            state_q <= SARC_CONV;
            cnt_q   <= conv_len(mode_s, master_rac);
          end
        end
        SARC_CONV: begin
          if (cnt_q <= 8'h01) begin
            state_q <= SARC_CAPT;
          end else begin
            cnt_q <= cnt_q - 8'h01;
          end
        end
        SARC_CAPT: state_q <= SARC_IDLE;
        default:   state_q <= SARC_IDLE;
      endcase
    end
  end

  // Busy is combinational so it rises with the start
  assign busy = start | (state_q == SARC_CONV) | (state_q == SARC_CAPT);

  // Result capture; reset release clears to zero in straight binary
  always_ff @(posedge clk) begin
    if (rst) begin
      result_out <= sarc_pkg::DATA_RST;
    end else if (rst_s_q && !rst_s) begin
      result_out <= ob_s ? sarc_pkg::DATA_RST : sarc_pkg::MSB_FLIP;
    end else if (state_q == SARC_CAPT && !rst_s) begin
      result_out <= ob_s ? core_result : (core_result ^ sarc_pkg::MSB_FLIP);
    end
  end

  // One-cycle strobe as busy drops, on the same edge that puts the result in place
  always_ff @(posedge clk) begin
    if (rst || rst_s) begin
      data_ready <= 1'b0;
    end else begin
      data_ready <= (state_q == SARC_CAPT);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Host bus gating, independent of power-down
  assign result_oe          = ~cs_n_s & ~rd_n_s;
  assign serial_clock_gated = ser_s & clkint_s & ~cs_n_s & sclk_s;

  ////////////////////////////////////////////////////////////////////////////
  // Config port: chip select deliberately not involved
  sarc_cfg_if cfg_bus ();
  assign cfg_bus.sel_n  = ccs_s;
  assign cfg_bus.sclk   = cclk_s;
  assign cfg_bus.sdata  = cdat_s;
  assign cfg_bus.invert = inv_s;
  assign cfg_bus.enable = ser_s & ~hwsw_s;

  logic cfg_rst;
  assign cfg_rst = rst | rst_s;
  sarc_cfg_shift u_cfg (
    .clk    (clk),
    .rst    (cfg_rst),
    .port_i (cfg_bus.shifter)
  );
  assign config_word = cfg_bus.cfg;

  ////////////////////////////////////////////////////////////////////////////
  property p_busy_rise;
    @(posedge clk) disable iff (rst)
      (state_q == SARC_IDLE && $fell(cnv_n_s) && !pd_s && !rst_s)
        |-> busy ##1 state_q == SARC_CONV;
  endproperty
  a_busy_rise: assert property (p_busy_rise) else $error("busy not high at start");
  property p_busy_until_capt;
    @(posedge clk) disable iff (rst) $fell(busy) |-> $past(state_q == SARC_CAPT) || rst_s;
  endproperty
  a_busy_until_capt: assert property (p_busy_until_capt) else $error("busy fell early");
  property p_ready;
    @(posedge clk) disable iff (rst || rst_s) $fell(busy) |-> data_ready;
  endproperty
  a_ready: assert property (p_ready) else $error("no data ready");
  property p_len;
    @(posedge clk) disable iff (rst) start |=> cnt_q == conv_len($past(mode_s), $past(master_rac));
  endproperty
  a_len: assert property (p_len) else $error("wrong busy length");
  property p_range;
    @(posedge clk) disable iff (rst) 1 |=> input_range == range_of($past(pol_s), $past(span_s));
  endproperty
  a_range: assert property (p_range) else $error("range decode wrong");
  property p_oe;
    @(posedge clk) disable iff (rst)
      result_oe == (!$past(chip_select_n, 2) && !$past(read_n, 2));
  endproperty
  a_oe: assert property (p_oe) else $error("bus enable wrong");
  property p_abort;
    @(posedge clk) disable iff (rst) rst_s |=> state_q == SARC_IDLE && !data_ready;
  endproperty
  a_abort: assert property (p_abort) else $error("reset did not abort");
  property p_pd;
    @(posedge clk) disable iff (rst) (pd_s && state_q == SARC_IDLE) |=> state_q == SARC_IDLE;
  endproperty
  a_pd: assert property (p_pd) else $error("start during power-down");
  property p_pd_run;
    @(posedge clk) disable iff (rst)
      (pd_s && !rst_s && state_q == SARC_CONV) |=> state_q != SARC_IDLE;
  endproperty
  a_pd_run: assert property (p_pd_run) else $error("power-down cut a conversion");
  property p_rst_data;
    @(posedge clk) disable iff (rst) ($fell(rst_s) && ob_s) |=> result_out == sarc_pkg::DATA_RST;
  endproperty
  a_rst_data: assert property (p_rst_data) else $error("data not cleared");

  c_conv: cover property (@(posedge clk) disable iff (rst) $fell(busy));
  c_rac:  cover property (@(posedge clk) disable iff (rst) start && master_rac);
  c_abort: cover property (@(posedge clk) disable iff (rst) state_q == SARC_CONV && rst_s);
endmodule : sarc_ctrl

// ### core/sarc_pkg.sv
// Package for the converter pin-control block: timing constants, range and mode types.
// Assumes one 40 MHz clock shared by every design file.
package sarc_pkg;
  localparam int unsigned CLK_NS          = 25;
  // Conversion and busy durations in ns, converted to cycles below
  localparam int unsigned CONV_NORMAL_NS  = 1500;
  localparam int unsigned CONV_WARP_NS    = 1250;
  localparam int unsigned CONV_IMPULSE_NS = 1900;
  localparam int unsigned EXTRA_RAC_NS    = 1000;
  localparam int unsigned CONV_NORMAL_CYC  = (CONV_NORMAL_NS + CLK_NS - 1) / CLK_NS;
  localparam int unsigned CONV_WARP_CYC    = (CONV_WARP_NS + CLK_NS - 1) / CLK_NS;
  localparam int unsigned CONV_IMPULSE_CYC = (CONV_IMPULSE_NS + CLK_NS - 1) / CLK_NS;
  localparam int unsigned EXTRA_RAC_CYC    = (EXTRA_RAC_NS + CLK_NS - 1) / CLK_NS;
  localparam int unsigned CNT_W           = 8;
  localparam int unsigned DATA_W          = 16;
  localparam int unsigned CFG_W           = 12;
  localparam logic [DATA_W-1:0] DATA_RST  = 16'h0000;
  localparam logic [DATA_W-1:0] MSB_FLIP  = 16'h8000;
  localparam logic [CFG_W-1:0]  CFG_RST   = 12'h000;
  // Synchroniser reset levels: the active-low pins (start, chip select, read, config
  // select) reset to their idle high level, so no false edge or bus enable follows reset
  localparam logic [18:0]       PIN_IDLE  = 19'h23008;

  typedef enum logic [1:0] {
    SARC_RANGE_UNI5,
    SARC_RANGE_UNI10,
    SARC_RANGE_BI5,
    SARC_RANGE_BI10
  } sarc_range_t;

  typedef enum logic [1:0] {
    SARC_MODE_NORMAL,
    SARC_MODE_WARP,
    SARC_MODE_IMPULSE,
    SARC_MODE_RSVD
  } sarc_mode_t;
endpackage : sarc_pkg

// ### dv/sarc_ctrl_tb.sv
// Self-checking bench for the converter pin-control block.
// Assumes the host model on chip select and read; all other pins are driven here.
`timescale 1ns/1ps
module sarc_ctrl_tb;
  logic        clk, rst, reset_pin, start_n, pwr_dn, pol, span, coding, serial;
  logic        ext_clk_sel, rd_conv, pin_cfg, ext_sclk, cfg_sel_n, cfg_clk, cfg_dat, inv;
  logic [1:0]  mode;
  logic [15:0] core;
  logic        busy, data_ready, result_oe, gated, cs_n, rd_n;
  logic [15:0] result_out;
  logic [11:0] config_word;
  sarc_pkg::sarc_range_t input_range;
  int          n_errors, checked;
  int          lens [4] = '{sarc_pkg::CONV_NORMAL_CYC + 2, sarc_pkg::CONV_WARP_CYC + 2,
                            sarc_pkg::CONV_IMPULSE_CYC + 2, sarc_pkg::CONV_NORMAL_CYC + 2};
  sarc_pkg::sarc_range_t exp_r [4] = '{sarc_pkg::SARC_RANGE_UNI5, sarc_pkg::SARC_RANGE_UNI10,
                                       sarc_pkg::SARC_RANGE_BI5, sarc_pkg::SARC_RANGE_BI10};

  sarc_ctrl sarc_ctrl_inst (.clk(clk), .rst(rst), .reset_pin(reset_pin),
    .convert_start_n(start_n), .power_down_in(pwr_dn), .range_polarity_select(pol),
    .range_span_select(span), .chip_select_n(cs_n), .read_n(rd_n),
    .output_coding_select(coding), .serial_parallel_select(serial),
    .clock_source_select(ext_clk_sel), .read_during_convert(rd_conv),
    .hardware_software_config_select(pin_cfg), .conv_mode_pins(mode),
    .ext_serial_clock(ext_sclk), .config_port_select(cfg_sel_n),
    .config_port_clock(cfg_clk), .config_port_data_in(cfg_dat), .serial_clock_invert(inv),
    .core_result(core), .busy(busy), .data_ready(data_ready), .input_range(input_range),
    .result_out(result_out), .result_oe(result_oe), .serial_clock_gated(gated),
    .config_word(config_word));

  sarc_host_model sarc_host_model_inst (.clk(clk), .busy(busy), .result_oe(result_oe),
    .result_out(result_out), .chip_select_n(cs_n), .read_n(rd_n));

  ////////////////////////////////////////////////////////////////////////////////
  // Free-running 40 MHz clock
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Compare, print and count
  task chk(input logic [15:0] got, input logic [15:0] exp);
    checked++;
    if (got !== exp) begin
      n_errors++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task end_sim();
    $display("errors %0d checks %0d", n_errors, checked);
    if (n_errors == 0 && checked > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : end_sim

  // One conversion; kind 1 raises power-down mid-way, kind 2 raises reset mid-way
  task run_conv(input int exp_len, input int kind);
    int n;
    int w;
    n = 0;
    w = 0;
    @(posedge clk) start_n <= 1'b0;
    while (busy !== 1'b1 && w < 10) begin
      @(posedge clk);
      #1;
      w++;
    end
    if (busy !== 1'b1) begin
      n_errors++;
      end_sim();
    end
    while (busy === 1'b1 && n < 300) begin
      @(posedge clk);
      start_n <= 1'b1;
      if (kind == 1 && n == 5) pwr_dn <= 1'b1;
      if (kind == 2 && n == 10) reset_pin <= 1'b1;
      #1;
      n++;
    end
    if (n >= 300) begin
      n_errors++;
      end_sim();
    end
    if (kind == 2) begin
      chk(16'(n < 16), 16'h0001);
      chk(16'(data_ready), 16'h0000);
    end else begin
      chk(16'(n), 16'(exp_len));
      chk(16'(data_ready), 16'h0001);
    end
  endtask : run_conv

  task rd_chk(input logic [15:0] exp);
    logic [15:0] v;
    logic        ok;
    sarc_host_model_inst.read_word(v, ok);
    chk(16'(ok), 16'h0001);
    chk(v, exp);
  endtask : rd_chk

  // Data flips between the two clock edges, so a wrong sampling edge shows up
  task shift_cfg(input logic [11:0] w, input logic lvl);
    for (int i = 11; i >= 0; i--) begin
      @(posedge clk) cfg_dat <= w[i];
      repeat (5) @(posedge clk);
      cfg_clk <= !lvl;
      repeat (5) @(posedge clk);
      cfg_dat <= !w[i];
      repeat (5) @(posedge clk);
      cfg_clk <= lvl;
    end
    repeat (8) @(posedge clk);
    #1;
  endtask : shift_cfg

  ////////////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial begin
    {rst, coding, ext_clk_sel, rd_conv, pin_cfg, cfg_sel_n} = 6'h3F;
    {reset_pin, pwr_dn, pol, span, serial, ext_sclk, cfg_clk, cfg_dat, inv} = 9'h000;
    start_n = 1'b1;
    mode = 2'h0;
    core = 16'h0000;
    n_errors = 0;
    checked = 0;
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    repeat (4) @(posedge clk);
    #1;
    chk(16'(busy), 16'h0000);
    chk(result_out, 16'h0000);
    chk(16'(config_word), 16'h0000);
    for (int m = 0; m < 4; m++) begin
      @(posedge clk) mode <= 2'(m);
      core <= 16'hA5C0 + 16'(m);
      repeat (4) @(posedge clk);
      run_conv(lens[m], 0);
      rd_chk(core);
    end
    // Two's complement coding, then master read-after-convert on and off
    @(posedge clk) coding <= 1'b0;
    run_conv(lens[0], 0);
    rd_chk(core ^ sarc_pkg::MSB_FLIP);
    @(posedge clk) {coding, serial, ext_clk_sel, rd_conv} <= 4'hC;
    repeat (4) @(posedge clk);
    run_conv(lens[0] + sarc_pkg::EXTRA_RAC_CYC, 0);
    @(posedge clk) rd_conv <= 1'b1;
    repeat (4) @(posedge clk);
    run_conv(lens[0], 0);
    @(posedge clk) {serial, ext_clk_sel} <= 2'h1;
    for (int r = 0; r < 4; r++) begin
      @(posedge clk) {pol, span} <= 2'(r);
      repeat (4) @(posedge clk);
      #1;
      chk(16'(input_range), 16'(exp_r[r]));
    end
    for (int i = 0; i < 4; i++) begin
      sarc_host_model_inst.set_lines(i[1], i[0]);
      repeat (4) @(posedge clk);
      #1;
      chk(16'(result_oe), 16'(i == 0));
    end
    // Slave serial clock gating by chip select
    @(posedge clk) {serial, ext_clk_sel, ext_sclk} <= 3'h7;
    for (int i = 0; i < 3; i++) begin
      sarc_host_model_inst.set_lines(i[0], 1'b1);
      if (i == 2) ext_sclk <= 1'b0;
      repeat (4) @(posedge clk);
      #1;
      chk(16'(gated), 16'(i == 0));
    end
    sarc_host_model_inst.set_lines(1'b1, 1'b1);
    @(posedge clk) serial <= 1'b0;
    run_conv(lens[0], 1);
    @(posedge clk) start_n <= 1'b0;
    repeat (20) @(posedge clk);
    #1;
    chk(16'(busy), 16'h0000);
    @(posedge clk) start_n <= 1'b1;
    rd_chk(core);
    chk(16'(sarc_host_model_inst.n_ready), 16'h0008);
    @(posedge clk) {pwr_dn, serial, pin_cfg, cfg_sel_n} <= 4'h4;
    repeat (4) @(posedge clk);
    shift_cfg(12'hA53, 1'b0);
    chk(16'(config_word), 16'h0A53);
    @(posedge clk) cfg_sel_n <= 1'b1;
    shift_cfg(12'h0FF, 1'b0);
    chk(16'(config_word), 16'h0A53);
    @(posedge clk) {cfg_sel_n, pin_cfg} <= 2'h1;
    shift_cfg(12'h0FF, 1'b0);
    chk(16'(config_word), 16'h0A53);
    @(posedge clk) {inv, cfg_clk} <= 2'h3;
    core <= 16'h7E11;
    run_conv(0, 2);
    repeat (4) @(posedge clk);
    reset_pin <= 1'b0;
    repeat (6) @(posedge clk);
    #1;
    chk(result_out, 16'h0000);
    chk(16'(config_word), 16'h0000);
    @(posedge clk) pin_cfg <= 1'b0;
    repeat (4) @(posedge clk);
    shift_cfg(12'h3C6, 1'b1);
    chk(16'(config_word), 16'h03C6);
    end_sim();
  end
endmodule : sarc_ctrl_tb

// ### dv/sarc_host_model.sv
// Host-side model: drives chip select and read, and reads result words off the bus.
// Assumes result_out is valid whenever result_oe is high.
`timescale 1ns/1ps
module sarc_host_model (
  input  wire logic                        clk,
  input  wire logic                        busy,
  input  wire logic                        result_oe,
  input  wire logic [sarc_pkg::DATA_W-1:0] result_out,
  output logic                             chip_select_n,
  output logic                             read_n
);
  logic        busy_q;
  int unsigned n_ready;

  initial begin
    chip_select_n = 1'b1;
    read_n = 1'b1;
    busy_q = 1'b0;
    n_ready = 0;
  end

  // Busy falling edge is taken as the data-ready strobe
  always @(posedge clk) begin
    busy_q <= busy;
    if (busy_q === 1'b1 && busy === 1'b0) n_ready <= n_ready + 1;
  end

  // Both lines change only just after a clock edge
  task set_lines(input logic cs_n, input logic rd_n);
    @(posedge clk);
    chip_select_n <= cs_n;
    read_n <= rd_n;
  endtask : set_lines

  // Hold both lines low until the bus is enabled or 8 edges pass, take the word at the enabling edge
  task read_word(output logic [sarc_pkg::DATA_W-1:0] v, output logic ok);
    ok = 1'b0;
    v = '0;
    set_lines(1'b0, 1'b0);
    for (int i = 0; i < 8 && !ok; i++) begin
      @(posedge clk);
      if (result_oe === 1'b1) begin
        v = result_out;
        ok = 1'b1;
      end
    end
    chip_select_n <= 1'b1;
    read_n <= 1'b1;
  endtask : read_word
endmodule : sarc_host_model
